// ==== rtl/capture_compare_timer16.sv ====
`timescale 1ns/1ps
`include "timer16_regs.svh"
module capture_compare_timer16 (
   input  wire logic                clk_i,        // cpu clock, 10 MHz
   input  wire logic                rst_i,        // sync reset
   input  wire logic                cyc_i,        // wishbone cycle
   input  wire logic                stb_i,        // wishbone strobe
   input  wire logic                we_i,         // write enable
   input  wire logic                sel_i,        // byte select
   input  wire timer16_pkg::addr_t  adr_i,        // register offset
   input  wire timer16_pkg::byte_t  dat_i,        // write data
   output timer16_pkg::byte_t       dat_o,        // read data
   output logic                     ack_o,        // wishbone ack
   input  wire logic                irq_mask_i,   // cpu global mask
   input  wire logic                halt_i,       // cpu halt mode
   input  wire logic                ext_clock_pin_i,       // external clock
   input  wire logic [1:0]          capture_input_pin_i,   // capture pins
   output logic [1:0]               compare_output_pin_o,  // compare pins
   output logic [1:0]               compare_output_enable_o, // pin owned
   output logic                     timer_irq_o   // timer interrupt
);
   import timer16_pkg::*;

   // bus side
   logic   ack_q;         // registered ack
   logic   acc;           // request accepted this cycle
   logic   rd;            // accepted read
   logic   wr;            // accepted write
   byte_t  dat_q;         // read data register

   // control registers
   byte_t  cr1_q;         // control_reg_one
   byte_t  cr2_q;         // control_reg_two

   // counter and clocking
   count_t cnt_q;         // free running counter
   logic [2:0] pre_q;     // prescaler
   logic   tick;          // timer clock enable
   logic   ext_edge;      // synchronised external edge
   logic   ovf;           // wrap this tick
   byte_t  lsb_buf_q;     // latched low byte
   logic   lsb_valid_q;   // latch holds a value

   // flags
   logic   tof_q;         // overflow_flag
   logic   tof_arm_q;     // status read saw tof
   logic [1:0] icf_q;     // capture_flag
   logic [1:0] icf_arm_q; // status read saw icf
   logic [1:0] ocf_q;     // compare_flag
   logic [1:0] ocf_arm_q; // status read saw ocf

   // capture
   count_t icr_q [2];     // capture_value_reg
   logic [1:0] cap_inh_q; // blocked after high read
   logic [1:0] cap_edge;  // synchronised capture edges
   logic [1:0] cap_ok;    // capture allowed
   logic [1:0] cap_go;    // capture taken

   // compare
   count_t ocr_q [2];     // compare_value_reg
   logic [1:0] cmp_inh_q; // blocked after high write
   logic [1:0] match;     // counter equals compare
   logic [1:0] ocf_ok;    // flag may set in mode
   logic [1:0] pin_q;     // compare pin latches
   logic [1:0] olvl;      // programmed levels
   logic   mode_alt;      // one-pulse or pwm

   // register selects
   logic   a_cntl;        // counter low
   logic   a_acntl;       // alternate low
   logic   a_cnth;        // either high byte
   logic [1:0] a_icl;     // capture low bytes
   logic [1:0] a_ich;     // capture high bytes
   logic [1:0] a_ocl;     // compare low bytes
   logic [1:0] a_och;     // compare high bytes

   // one-cycle classic handshake
   assign acc = cyc_i & stb_i & ~ack_q;
   assign rd  = acc & ~we_i;
   assign wr  = acc & we_i & sel_i;

   // address compare
   assign a_cntl  = (adr_i == `T16_CNTL_OFS);
   assign a_acntl = (adr_i == `T16_ACNTL_OFS);
   assign a_cnth  = (adr_i == `T16_CNTH_OFS) | (adr_i == `T16_ACNTH_OFS);
   assign a_icl   = {adr_i == `T16_IC2L_OFS, adr_i == `T16_IC1L_OFS};
   assign a_ich   = {adr_i == `T16_IC2H_OFS, adr_i == `T16_IC1H_OFS};
   assign a_ocl   = {adr_i == `T16_OC2L_OFS, adr_i == `T16_OC1L_OFS};
   assign a_och   = {adr_i == `T16_OC2H_OFS, adr_i == `T16_OC1H_OFS};

   // ack one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // control register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cr1_q <= `T16_CR_RST;
         cr2_q <= `T16_CR_RST;
      end else if (wr && adr_i == `T16_CR1_OFS) begin
         cr1_q <= dat_i & `T16_CR1_WMASK;
      end else if (wr && adr_i == `T16_CR2_OFS) begin
         cr2_q <= dat_i;
      end
   end

   assign mode_alt = cr2_q[`T16_CR2_OPM] | cr2_q[`T16_CR2_PWM];
   assign olvl     = {cr1_q[`T16_CR1_OLVL2], cr1_q[`T16_CR1_OLVL1]};

   edge_sync u_ext (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (ext_clock_pin_i),
      .rise_i (cr2_q[`T16_CR2_EXT_CLOCK_EDGE_SELECT]),
      .edge_o (ext_edge)
   );

   edge_sync u_cap1 (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (capture_input_pin_i[0]),
      .rise_i (cr1_q[`T16_CR1_IEDG1]),
      .edge_o (cap_edge[0])
   );
   edge_sync u_cap2 (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (capture_input_pin_i[1]),
      .rise_i (cr2_q[`T16_CR2_IEDG2]),
      .edge_o (cap_edge[1])
   );

   // prescaler, frozen in halt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= 3'h0;
      end else if (!halt_i) begin
         pre_q <= pre_q + 3'h1;
      end
   end

   always_comb begin
      tick = 1'b0;
      if (halt_i) begin
         tick = 1'b0;
      end else begin
         case (cr2_q[`T16_CR2_CC1:`T16_CR2_CC0])
            2'b00:   tick = (pre_q[1:0] == 2'h3);  // divide by 4
            2'b01:   tick = pre_q[0];              // divide by 2
            2'b10:   tick = (pre_q == 3'h7);       // divide by 8
            default: tick = ext_edge;              // external pin
         endcase
      end
   end

   assign ovf = tick & (cnt_q == `T16_CNT_MAX);

   // counter, reload on low byte writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= `T16_CNT_RST;
      end else if (wr && (a_cntl || a_acntl)) begin
         cnt_q <= `T16_CNT_RST;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // latch low byte on first high read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lsb_buf_q   <= 8'h00;
         lsb_valid_q <= 1'b0;
      end else if (rd && a_cnth && !lsb_valid_q) begin
         lsb_buf_q   <= cnt_q[7:0];
         lsb_valid_q <= 1'b1;
      end else if (rd && (a_cntl || a_acntl)) begin
         lsb_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tof_q     <= 1'b0;
         tof_arm_q <= 1'b0;
      end else begin
         if (ovf) begin
            tof_q <= 1'b1;
         end else if (acc && a_cntl && tof_arm_q) begin
            tof_q <= 1'b0;
         end
         if (acc && a_cntl) begin
            tof_arm_q <= 1'b0;
         end else if (rd && adr_i == `T16_SR_OFS && tof_q) begin
            tof_arm_q <= 1'b1;
         end
      end
   end

   // channel one idle in one-pulse or pwm
   assign cap_ok = {1'b1, ~mode_alt} & ~cap_inh_q;
   assign cap_go = cap_edge & cap_ok;

   for (genvar i = 0; i < 2; i++) begin : g_cap
      // capture register, newest wins
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            icr_q[i] <= 16'h0000;
         end else if (cap_go[i]) begin
            icr_q[i] <= cnt_q;
         end
      end
      // high read blocks until low read
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cap_inh_q[i] <= 1'b0;
         end else if (rd && a_ich[i]) begin
            cap_inh_q[i] <= 1'b1;
         end else if (rd && a_icl[i]) begin
            cap_inh_q[i] <= 1'b0;
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            icf_q[i]     <= 1'b0;
            icf_arm_q[i] <= 1'b0;
         end else begin
            if (cap_go[i]) begin
               icf_q[i] <= 1'b1;
            end else if (acc && a_icl[i] && icf_arm_q[i]) begin
               icf_q[i] <= 1'b0;
            end
            if (acc && a_icl[i]) begin
               icf_arm_q[i] <= 1'b0;
            end else if (rd && adr_i == `T16_SR_OFS && icf_q[i]) begin
               icf_arm_q[i] <= 1'b1;
            end
         end
      end
   end

   // flag suppression in one-pulse and pwm
   assign ocf_ok = cr2_q[`T16_CR2_PWM] ? 2'b00 :
                   (cr2_q[`T16_CR2_OPM] ? 2'b10 : 2'b11);

   for (genvar i = 0; i < 2; i++) begin : g_cmp
      assign match[i] = (cnt_q == ocr_q[i]) & ~cmp_inh_q[i];
      // compare value, software only
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ocr_q[i] <= `T16_OC_RST;
         end else if (wr && a_och[i]) begin
            ocr_q[i][15:8] <= dat_i;
         end else if (wr && a_ocl[i]) begin
            ocr_q[i][7:0] <= dat_i;
         end
      end
      // high write suspends compare
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cmp_inh_q[i] <= 1'b0;
         end else if (wr && a_och[i]) begin
            cmp_inh_q[i] <= 1'b1;
         end else if (wr && a_ocl[i]) begin
            cmp_inh_q[i] <= 1'b0;
         end
      end
      // compare flag, set wins
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ocf_q[i]     <= 1'b0;
            ocf_arm_q[i] <= 1'b0;
         end else begin
            if (match[i] && ocf_ok[i]) begin
               ocf_q[i] <= 1'b1;
            end else if (acc && a_ocl[i] && ocf_arm_q[i]) begin
               ocf_q[i] <= 1'b0;
            end
            if (acc && a_ocl[i]) begin
               ocf_arm_q[i] <= 1'b0;
            end else if (rd && adr_i == `T16_SR_OFS && ocf_q[i]) begin
               ocf_arm_q[i] <= 1'b1;
            end
         end
      end
      // pin latch, low during reset
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pin_q[i] <= 1'b0;
         end else if (match[i]) begin
            pin_q[i] <= olvl[i];
         end
      end
   end

   assign compare_output_enable_o = {cr2_q[`T16_CR2_OC2E], cr2_q[`T16_CR2_OC1E]};
   assign compare_output_pin_o    = pin_q & compare_output_enable_o;

   assign timer_irq_o = ~irq_mask_i &
      ((tof_q & cr1_q[`T16_CR1_OVERFLOW_IRQ_ENABLE]) |
       ((|icf_q) & cr1_q[`T16_CR1_CAPTURE_IRQ_ENABLE]) |
       ((|ocf_q) & cr1_q[`T16_CR1_COMPARE_IRQ_ENABLE]));

   // read data mux, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 8'h00;
      end else if (rd) begin
         if (adr_i == `T16_CR1_OFS) begin
            dat_q <= cr1_q;
         end else if (adr_i == `T16_CR2_OFS) begin
            dat_q <= cr2_q;
         end else if (adr_i == `T16_SR_OFS) begin
            dat_q <= {icf_q[0], ocf_q[0], tof_q, icf_q[1], ocf_q[1], 3'h0};
         end else if (a_cnth) begin
            dat_q <= cnt_q[15:8];
         end else if (a_cntl || a_acntl) begin
            dat_q <= lsb_valid_q ? lsb_buf_q : cnt_q[7:0];
         end else if (a_ich[0]) begin
            dat_q <= icr_q[0][15:8];
         end else if (a_icl[0]) begin
            dat_q <= icr_q[0][7:0];
         end else if (a_ich[1]) begin
            dat_q <= icr_q[1][15:8];
         end else if (a_icl[1]) begin
            dat_q <= icr_q[1][7:0];
         end else if (a_och[0]) begin
            dat_q <= ocr_q[0][15:8];
         end else if (a_ocl[0]) begin
            dat_q <= ocr_q[0][7:0];
         end else if (a_och[1]) begin
            dat_q <= ocr_q[1][15:8];
         end else if (a_ocl[1]) begin
            dat_q <= ocr_q[1][7:0];
         end else begin
            dat_q <= 8'h00;
         end
      end
   end

   // latch holds until low byte read
   AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      lsb_valid_q && !(rd && (a_cntl || a_acntl)) |=> $stable(lsb_buf_q) && lsb_valid_q)
      else $error("latched low byte changed");

   // unlatched low read gives live count
   AST_LIVE_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      rd && a_cntl && !lsb_valid_q |=> dat_o == $past(cnt_q[7:0]))
      else $error("live low byte wrong");

   // wrap sets overflow flag
   AST_OVF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && cnt_q == 16'hffff && !(wr && (a_cntl || a_acntl)) |=> tof_q && cnt_q == 16'h0000)
      else $error("overflow flag not set on wrap");

   // unmasked enabled overflow raises irq
   AST_OVF_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      tof_q && cr1_q[5] && !irq_mask_i |-> timer_irq_o)
      else $error("overflow irq missing");

   // no clear without prior status read
   AST_TOF_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
      tof_q && !tof_arm_q |=> tof_q)
      else $error("overflow cleared without status read");

   // alternate low never clears overflow
   AST_ALT_COUNTER_LOW_BYTE_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
      tof_q && acc && a_acntl |=> tof_q)
      else $error("alternate access cleared overflow");

   // halt freezes the count
   AST_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
      halt_i && !wr |=> $stable(cnt_q))
      else $error("counter moved in halt");

   // capture copies count and flags
   AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_go[1] |=> icr_q[1] == $past(cnt_q) && icf_q[1])
      else $error("capture value or flag wrong");

   // blocked capture keeps old value
   AST_CAP_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_inh_q[0] && !(rd && a_icl[0]) |=> $stable(icr_q[0]))
      else $error("capture changed while blocked");

   // match drives programmed level
   AST_CMP_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
      match[0] && cr2_q[7] |=> compare_output_pin_o[0] == $past(olvl[0]))
      else $error("compare pin level wrong");

   // low byte write reloads counter
   AST_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && a_cntl |=> cnt_q == 16'hfffc)
      else $error("counter not reloaded");
endmodule // capture_compare_timer16

// ==== rtl/edge_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser plus selectable edge detector
module edge_sync (
   input  wire logic clk_i,       // cpu clock
   input  wire logic rst_i,       // sync reset
   input  wire logic pin_i,       // asynchronous pin
   input  wire logic rise_i,      // 1 rising, 0 falling
   output logic      edge_o       // one-cycle pulse
);
   logic meta_q;    // first stage, read only by sync_q
   logic sync_q;    // second stage
   logic prev_q;    // delayed copy for edges

   // synchroniser chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // edge selected by polarity
   always_comb begin
      if (rise_i) begin
         edge_o = sync_q & ~prev_q;
      end else begin
         edge_o = ~sync_q & prev_q;
      end
   end
endmodule // edge_sync

// ==== rtl/timer16_pkg.sv ====
package timer16_pkg;
   typedef logic [7:0]  byte_t;   // one bus byte
   typedef logic [15:0] count_t;  // counter width value
   typedef logic [3:0]  addr_t;   // register offset
endpackage

// ==== rtl/timer16_regs.svh ====
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH
// byte register offsets on the wishbone bus
`define T16_CR2_OFS     4'h0
`define T16_CR1_OFS     4'h1
`define T16_SR_OFS      4'h2
`define T16_IC1H_OFS    4'h3
`define T16_IC1L_OFS    4'h4
`define T16_OC1H_OFS    4'h5
`define T16_OC1L_OFS    4'h6
`define T16_CNTH_OFS    4'h7
`define T16_CNTL_OFS    4'h8
`define T16_ACNTH_OFS   4'h9
`define T16_ACNTL_OFS   4'ha
`define T16_IC2H_OFS    4'hb
`define T16_IC2L_OFS    4'hc
`define T16_OC2H_OFS    4'hd
`define T16_OC2L_OFS    4'he
// control register one fields
`define T16_CR1_CAPTURE_IRQ_ENABLE    7
`define T16_CR1_COMPARE_IRQ_ENABLE    6
`define T16_CR1_OVERFLOW_IRQ_ENABLE    5
`define T16_CR1_OLVL2   2
`define T16_CR1_IEDG1   1
`define T16_CR1_OLVL1   0
// control register two fields
`define T16_CR2_OC1E    7
`define T16_CR2_OC2E    6
`define T16_CR2_OPM     5
`define T16_CR2_PWM     4
`define T16_CR2_CC1     3
`define T16_CR2_CC0     2
`define T16_CR2_IEDG2   1
`define T16_CR2_EXT_CLOCK_EDGE_SELECT   0
// writable bits (forced compare bits read as zero)
`define T16_CR1_WMASK   8'he7
// reset values and counter maximum
`define T16_CNT_RST     16'hfffc
`define T16_CNT_MAX     16'hffff
`define T16_OC_RST      16'h8000
`define T16_CR_RST      8'h00
`endif

// ==== verification/capture_compare_timer16_tb.sv ====
`timescale 1ns/1ps
`include "timer16_regs.svh"
// bench driving the timer over wishbone and through its pins
module capture_compare_timer16_tb;
   import timer16_pkg::*;
   logic       clk, rst, cyc, stb, we, irq_mask, halt, ext_tog, ext_pin, irq;  // single-bit nets
   logic [1:0] cap_tog, cap_pin, cmp_pin, cmp_en;                             // per-channel pins
   addr_t      adr;                                                           // register offset
   byte_t      dat_w, dat_r;                                                  // bus data
   logic       ack;                                                           // bus answer
   int         compares    = 0;                                               // checks made
   int         miscompares = 0;                                               // checks failed
   addr_t      och[2] = '{`T16_OC1H_OFS, `T16_OC2H_OFS};                      // compare high bytes
   addr_t      ocl[2] = '{`T16_OC1L_OFS, `T16_OC2L_OFS};                      // compare low bytes
   byte_t      ocf[2] = '{8'h40, 8'h08};                                      // compare flag masks

   capture_compare_timer16 u_capture_compare_timer16 (
      .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(1'b1),
      .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .irq_mask_i(irq_mask),
      .halt_i(halt), .ext_clock_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
      .compare_output_pin_o(cmp_pin), .compare_output_enable_o(cmp_en), .timer_irq_o(irq));

   timer_pins_model u_timer_pins_model (
      .clk_i(clk), .rst_i(rst), .ext_tog_i(ext_tog), .cap_tog_i(cap_tog),
      .ext_pin_o(ext_pin), .cap_pin_o(cap_pin));

   // free-running cpu clock, 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // verdict and end of run
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic check(input byte_t seen, input byte_t exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic wishbone cycle, bounded wait for ack
   task automatic wb(input logic w, input addr_t a, input byte_t d, output byte_t q);
      int n;
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         miscompares++;
         wrap_up();
      end
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input addr_t a, input byte_t d);
      byte_t q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input addr_t a, output byte_t q);
      wb(1'b0, a, 8'h00, q);
   endtask

   // read and compare the masked bits
   task automatic rdc(input addr_t a, input byte_t m, input byte_t e);
      byte_t q;
      rd(a, q);
      check(q & m, e);
   endtask

   // pin edges: bit 2 external clock, bits 1:0 capture pins
   task automatic pin_edge(input logic [2:0] m);
      {ext_tog, cap_tog} <= m;
      @(posedge clk);
      {ext_tog, cap_tog} <= 3'h0;
      repeat (9) @(posedge clk);
   endtask

   // main sequence
   initial begin
      byte_t v1, v2, h, l;
      {rst, irq_mask} = 2'b11;
      {cyc, stb, we, halt, ext_tog, cap_tog} = 7'h00;
      adr   = 4'h0;
      dat_w = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values and an unmapped place
      rdc(`T16_OC1H_OFS, 8'hff, 8'h80);
      rdc(`T16_OC2L_OFS, 8'hff, 8'h00);
      rdc(4'hf, 8'hff, 8'h00);
      check({4'h0, cmp_pin, cmp_en}, 8'h00);
      // overflow flag, pending irq, two-step clear
      wr(`T16_CR1_OFS, 8'h20);
      repeat (20) @(posedge clk);
      rdc(`T16_SR_OFS, 8'h20, 8'h20);
      check({7'h0, irq}, 8'h00);
      irq_mask <= 1'b0;
      @(posedge clk);
      check({7'h0, irq}, 8'h01);
      halt <= 1'b1;
      rd(`T16_ACNTL_OFS, v1);
      rdc(`T16_SR_OFS, 8'h20, 8'h20);
      wr(`T16_CNTL_OFS, 8'h00);
      rdc(`T16_SR_OFS, 8'h20, 8'h00);
      check({7'h0, irq}, 8'h00);
      // reload, buffered read, live read, halt freeze
      rdc(`T16_CNTH_OFS, 8'hff, 8'hff);
      rdc(`T16_CNTL_OFS, 8'hff, 8'hfc);
      halt <= 1'b0;
      rd(`T16_CNTH_OFS, v1);
      repeat (40) @(posedge clk);
      rd(`T16_CNTH_OFS, v1);
      rd(`T16_CNTL_OFS, v1);
      rd(`T16_CNTL_OFS, v2);
      check({7'h0, v1 >= 8'hfc}, 8'h01);
      v2 = v2 - v1;
      check({7'h0, v2 >= 8'd10 && v2 <= 8'd16}, 8'h01);
      halt <= 1'b1;
      rd(`T16_CNTL_OFS, v1);
      repeat (20) @(posedge clk);
      rdc(`T16_CNTL_OFS, 8'hff, v1);
      // output compare on both channels
      wr(`T16_CNTL_OFS, 8'h00);
      wr(`T16_CR1_OFS, 8'h45);
      wr(`T16_CR2_OFS, 8'hc0);
      check({6'h0, cmp_en}, 8'h03);
      for (int i = 0; i < 2; i++) begin
         wr(och[i], 8'hff);
         wr(ocl[i], 8'hfc);
         repeat (3) @(posedge clk);
         check({7'h0, cmp_pin[i]}, 8'h01);
         check({7'h0, irq}, 8'h01);
         wr(och[i], 8'h00);
         rdc(`T16_SR_OFS, ocf[i], ocf[i]);
         wr(ocl[i], 8'h00);
         rdc(`T16_SR_OFS, ocf[i], 8'h00);
         rdc(och[i], 8'hff, 8'h00);
         check({7'h0, irq}, 8'h00);
      end
      // input capture, blocking and overwrite
      wr(`T16_CR1_OFS, 8'h82);
      wr(`T16_CR2_OFS, 8'h00);
      pin_edge(3'h1);
      rdc(`T16_SR_OFS, 8'h80, 8'h80);
      check({7'h0, irq}, 8'h01);
      rdc(`T16_IC1H_OFS, 8'hff, 8'hff);
      rdc(`T16_IC1L_OFS, 8'hff, 8'hfc);
      rdc(`T16_SR_OFS, 8'h80, 8'h00);
      rd(`T16_IC1H_OFS, v1);
      pin_edge(3'h1);
      pin_edge(3'h1);
      rdc(`T16_SR_OFS, 8'h80, 8'h00);
      rd(`T16_IC1L_OFS, v1);
      halt <= 1'b0;
      repeat (20) @(posedge clk);
      halt <= 1'b1;
      rd(`T16_CNTH_OFS, h);
      rd(`T16_CNTL_OFS, l);
      pin_edge(3'h1);
      pin_edge(3'h1);
      rdc(`T16_IC1H_OFS, 8'hff, h);
      rdc(`T16_IC1L_OFS, 8'hff, l);
      pin_edge(3'h2);
      rdc(`T16_SR_OFS, 8'h10, 8'h00);
      pin_edge(3'h2);
      rdc(`T16_SR_OFS, 8'h10, 8'h10);
      rdc(`T16_IC2H_OFS, 8'hff, h);
      rdc(`T16_IC2L_OFS, 8'hff, l);
      // prescaler ratios 2, 4 and 8 over 64 cycles
      for (int k = 0; k < 3; k++) begin
         wr(`T16_CR2_OFS, k == 0 ? 8'h04 : (k == 1 ? 8'h00 : 8'h08));
         wr(`T16_CNTL_OFS, 8'h00);
         halt <= 1'b0;
         repeat (64) @(posedge clk);
         halt <= 1'b1;
         rd(`T16_CNTL_OFS, v1);
         v1 = v1 - 8'hfc - 8'(64 >> (k + 1)) + 8'h01;
         check({7'h0, v1 <= 8'h02}, 8'h01);
      end
      // external clock, rising then falling edges
      wr(`T16_CR2_OFS, 8'h0d);
      wr(`T16_CNTL_OFS, 8'h00);
      halt <= 1'b0;
      repeat (3) pin_edge(3'h4);
      wr(`T16_CR2_OFS, 8'h0c);
      pin_edge(3'h4);
      rdc(`T16_CNTH_OFS, 8'hff, 8'hff);
      rdc(`T16_CNTL_OFS, 8'hff, 8'hff);
      // one-pulse mode leaves capture one idle
      rd(`T16_SR_OFS, v1);
      rd(`T16_IC1L_OFS, v1);
      rdc(`T16_SR_OFS, 8'h80, 8'h00);
      wr(`T16_CR2_OFS, 8'h20);
      pin_edge(3'h1);
      pin_edge(3'h1);
      rdc(`T16_SR_OFS, 8'h80, 8'h00);
      wrap_up();
   end
endmodule // capture_compare_timer16_tb

// ==== verification/timer_pins_model.sv ====
`timescale 1ns/1ps
// far-side pin model: capture sources and the external clock source
module timer_pins_model (
   input  wire logic       clk_i,      // cpu clock
   input  wire logic       rst_i,      // sync reset
   input  wire logic       ext_tog_i,  // request one external clock edge
   input  wire logic [1:0] cap_tog_i,  // request capture pin edges
   output logic            ext_pin_o,  // external clock pin
   output logic [1:0]      cap_pin_o   // capture pins
);
   logic [2:0] gap_q;  // cycles since the last external edge

   // external clock edges, never closer than four cpu cycles
   // edge spacing kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_pin_o <= 1'b0;
         gap_q     <= 3'h0;
      end else if (ext_tog_i && gap_q >= 3'h4) begin
         ext_pin_o <= ~ext_pin_o;
         gap_q     <= 3'h0;
      end else if (gap_q != 3'h7) begin
         gap_q <= gap_q + 3'h1;
      end
   end

   // capture pins flip on request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_pin_o <= 2'h0;
      end else begin
         cap_pin_o <= cap_pin_o ^ cap_tog_i;
      end
   end
endmodule // timer_pins_model
